// ---- logic/bcc_ctrl.sv ----
// Purpose: Commissioning entry, inhibit and factory reset of a four-contact
//          pushbutton transmitter, with its configuration registers.
// Assumes: Contacts are active high and asynchronous; a 1 ms tick paces all
//          timing.
// Notes: Telegram requests are one-cycle pulses to the transmitter.
`timescale 1ns/1ps

module bcc_ctrl
    import bcc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter logic [127:0] FACTORY_KEY = 128'h0,
    parameter logic [47:0] FACTORY_ADDR = 48'h0,
    // Arbitrary neutral maker code.
    parameter logic [15:0] FACTORY_MFR = 16'h1234
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [3:0] i_contacts,
    input wire bcc_req_type i_req,
    output logic [31:0] o_rdata,
    output bcc_tel_type o_tel,
    output logic [15:0] o_len_type,
    output logic [15:0] o_mfr,
    output logic [127:0] o_key,
    output logic [47:0] o_src_addr,
    output logic o_factory_reset,
    output logic o_perm_inhibit
);

    typedef struct packed {
        logic [3:0] sync_a;
        logic [3:0] sync_b;
        logic [3:0] stable;
        logic [3:0][4:0] deb;
        logic [3:0][MSW-1:0] hold;
        logic [15:0] tick_cnt;
        logic tick;
        bcc_seq_type seq;
        logic [1:0] seq_btn;
        logic comm;
        logic [1:0] comm_btn;
        logic [MSW-1:0] inh_ms;
        logic [MSW-1:0] fr_ms;
        logic perm_inh;
        logic [7:0] cfg;
        logic [7:0] variant;
        logic [31:0] pin;
        logic [15:0] mfr;
        logic [47:0] addr;
        logic [127:0] key;
        logic [127:0] keyw;
        logic key_priv;
        logic [31:0] rdata;
        logic send_comm;
        logic send_data;
        logic fr_pulse;
    } bcc_state_type;

    bcc_state_type s;
    bcc_state_type n;

    function automatic logic [MSW-1:0] ms_inc(input logic [MSW-1:0] v);
        ms_inc = (v == HOLD_MAX) ? v : v + 14'h0001;
    endfunction

    function automatic logic [31:0] key_word(input logic [127:0] k,
                                             input logic [1:0] w);
        key_word = k[32*w +: 32];
    endfunction

    // Keys sit in 16-byte pages; address bits 3:2 pick the word.
    function automatic logic page_hit(input logic [7:0] a,
                                      input logic [7:0] base);
        page_hit = (a[7:4] == base[7:4]);
    endfunction

    always_comb begin
        logic [3:0] press;
        logic [3:0] rel;
        logic [3:0] btn_mask;
        logic fr_combo;
        logic inh_combo;
        logic [1:0] w;
        press = 4'h0;
        rel = 4'h0;
        btn_mask = 4'h0;
        fr_combo = 1'b0;
        inh_combo = 1'b0;
        w = i_req.addr[3:2];
        n = s;
        // Two flops settle a contact that moves close to a clock edge.
        n.sync_a = i_contacts;
        n.sync_b = s.sync_a;
        n.send_comm = 1'b0;
        n.send_data = 1'b0;
        n.fr_pulse = 1'b0;
        n.tick = 1'b0;
        // One divider paces every millisecond figure, so all timers share it.
        if (s.tick_cnt == 16'(TICK_CYCLES - 1)) begin
            n.tick_cnt = 16'h0000;
            n.tick = 1'b1;
        end else begin
            n.tick_cnt = s.tick_cnt + 16'h0001;
        end

        for (int i = 0; i < 4; i++) begin
            // A level must stay changed for the whole filter time.
            if (s.sync_b[i] == s.stable[i]) begin
                n.deb[i] = 5'h00;
            end else if (s.tick) begin
                if (s.deb[i] == DEB_MS - 5'h01) begin
                    n.stable[i] = s.sync_b[i];
                    n.deb[i] = 5'h00;
                end else begin
                    n.deb[i] = s.deb[i] + 5'h01;
                end
            end
            // Hold times saturate, so a contact held for minutes reads long.
            if (s.tick && s.stable[i]) begin
                n.hold[i] = ms_inc(s.hold[i]);
            end
        end
        press = n.stable & ~s.stable;
        rel = s.stable & ~n.stable;
        for (int i = 0; i < 4; i++) begin
            if (press[i]) begin
                n.hold[i] = '0;
            end
        end

        // Release of a lone contact drives the long-short-long sequence.
        for (int i = 0; i < 4; i++) begin
            if (rel[i]) begin
                // A release beside, or together with, another contact is
                // not part of a sequence and starts it over.
                if (s.stable != (4'h1 << i) || n.stable != 4'h0) begin
                    n.seq = SEQ_IDLE;
                end else begin
                    case (s.seq)
                        SEQ_IDLE: begin
                            if (s.hold[i] > LONG_MS) begin
                                n.seq = SEQ_LONG1;
                                n.seq_btn = 2'(i);
                            end
                        end
                        SEQ_LONG1: begin
                            if (s.seq_btn == 2'(i) &&
                                s.hold[i] < SHORT_MS) begin
                                n.seq = SEQ_SHORT;
                            end else if (s.hold[i] > LONG_MS) begin
                                n.seq_btn = 2'(i);
                            end else begin
                                n.seq = SEQ_IDLE;
                            end
                        end
                        SEQ_SHORT: begin
                            n.seq = SEQ_IDLE;
                            if (s.seq_btn == 2'(i) &&
                                s.hold[i] > LONG_MS &&
                                !s.cfg[CFG_LEARN_INH] &&
                                !s.perm_inh) begin
                                n.comm = 1'b1;
                                n.comm_btn = 2'(i);
                            end
                        end
                        default: n.seq = SEQ_IDLE;
                    endcase
                end
            end
        end

        // Telegram requests from contact edges.
        btn_mask = 4'h1 << s.comm_btn;
        if (s.comm) begin
            // The press that ends the mode is itself reported as data.
            if ((press & ~btn_mask) != 4'h0) begin
                n.comm = 1'b0;
                n.send_data = 1'b1;
            end else if (((press | rel) & btn_mask) != 4'h0) begin
                n.send_comm = 1'b1;
            end
        end else if (n.comm) begin
            // Entry itself sends the first commissioning telegram.
            n.send_comm = 1'b1;
        end else if ((press | rel) != 4'h0) begin
            n.send_data = 1'b1;
        end

        // Both combination timers run on the debounced contacts.
        // Only exactly two diagonal contacts count: the three-contact inhibit
        // combination holds a diagonal too and must stay reachable.
        fr_combo = (n.stable == FR_DIAG_A) || (n.stable == FR_DIAG_B);
        inh_combo = (n.stable & INH_MASK) == INH_MASK;
        if (inh_combo) begin
            if (s.tick) begin
                n.inh_ms = ms_inc(s.inh_ms);
            end
        end else begin
            // The inhibit takes hold on release, once the user lets go.
            if (s.inh_ms >= COMBO_MS) begin
                n.perm_inh = 1'b1;
            end
            n.inh_ms = '0;
        end
        if (!fr_combo) begin
            n.fr_ms = '0;
        end else if (s.tick) begin
            n.fr_ms = ms_inc(s.fr_ms);
        end

        // Register writes from software.
        if (i_req.wr) begin
            if (i_req.addr == REG_CONFIG) begin
                n.cfg = i_req.wdata[7:0];
            end else if (i_req.addr == REG_VARIANT) begin
                n.variant = i_req.wdata[7:0];
            end else if (i_req.addr == REG_PIN) begin
                n.pin = i_req.wdata;
            end else if (i_req.addr == REG_MFR) begin
                n.mfr = i_req.wdata[15:0];
            end else if (i_req.addr == REG_ADDR_LO) begin
                n.addr[31:0] = i_req.wdata;
            end else if (i_req.addr == REG_ADDR_HI) begin
                n.addr[47:32] = i_req.wdata[15:0];
            end else if (page_hit(i_req.addr, REG_KEYW0)) begin
                // The live key follows at once, so telegrams use the new key.
                n.keyw[32*w +: 32] = i_req.wdata;
                n.key[32*w +: 32] = i_req.wdata;
                // Once hidden, the key stays hidden until a factory reset.
                if (s.cfg[CFG_KEY_PRIV]) begin
                    n.key_priv = 1'b1;
                end
            end
        end

        // Factory reset wins over every other detection.
        if (fr_combo && s.tick && s.fr_ms == COMBO_MS) begin
            n.fr_pulse = 1'b1;
            n.seq = SEQ_IDLE;
            n.inh_ms = '0;
            n.comm = 1'b0;
            n.send_comm = 1'b0;
            n.perm_inh = 1'b0;
            n.addr = FACTORY_ADDR;
            n.key = FACTORY_KEY;
            n.keyw = FACTORY_KEY;
            n.key_priv = 1'b0;
            n.mfr = FACTORY_MFR;
            n.pin = PIN_RST;
            n.cfg = CFG_RST;
            n.variant = CFG_RST;
        end else if (fr_combo) begin
            // Clearing here keeps the release of a diagonal from counting.
            n.seq = SEQ_IDLE;
            n.inh_ms = '0;
        end

        // Read data stands for the single cycle after the strobe.
        n.rdata = 32'h0000_0000;
        // The PIN has no read path, so it cannot leak through the port.
        if (i_req.rd) begin
            if (i_req.addr == REG_CONFIG) begin
                n.rdata = {24'h000000, s.cfg};
            end else if (i_req.addr == REG_VARIANT) begin
                n.rdata = {24'h000000, s.variant};
            end else if (i_req.addr == REG_MFR) begin
                n.rdata = {16'h0000, s.mfr};
            end else if (i_req.addr == REG_ADDR_LO) begin
                n.rdata = s.addr[31:0];
            end else if (i_req.addr == REG_ADDR_HI) begin
                n.rdata = {16'h0000, s.addr[47:32]};
            end else if (i_req.addr == REG_STATUS) begin
                // Status packs the debounced contacts beside the mode bits.
                n.rdata = {24'h000000, s.stable, s.comm_btn,
                           s.perm_inh, s.comm};
            end else if (page_hit(i_req.addr, REG_KEY0)) begin
                n.rdata = s.key_priv ? 32'h0000_0000 : key_word(s.key, w);
            end else if (page_hit(i_req.addr, REG_KEYW0)) begin
                n.rdata = s.key_priv ? 32'h0000_0000 : key_word(s.keyw, w);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            // Power-up loads the same factory values as a factory reset.
            s <= '0;
            s.seq <= SEQ_IDLE;
            s.cfg <= CFG_RST;
            s.variant <= CFG_RST;
            s.pin <= PIN_RST;
            s.mfr <= FACTORY_MFR;
            s.addr <= FACTORY_ADDR;
            s.key <= FACTORY_KEY;
            s.keyw <= FACTORY_KEY;
        end else begin
            s <= n;
        end
    end

    // The length and type bytes are registered constants; the other payload fields come straight from the stored registers.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_len_type <= 16'h0000;
        end else begin
            o_len_type <= {TEL_LEN, TEL_TYPE};
        end
    end

    assign o_rdata = s.rdata;
    assign o_tel = '{send_comm: s.send_comm, send_data: s.send_data,
                     comm_mode: s.comm, buttons: s.stable};
    assign o_mfr = s.mfr;
    assign o_key = s.key;
    assign o_src_addr = s.addr;
    assign o_factory_reset = s.fr_pulse;
    assign o_perm_inhibit = s.perm_inh;

endmodule

// ---- logic/bcc_pkg.sv ----
// Purpose: Shared constants and carriers of the button commissioning control.
// Assumes: A 25 MHz clock and a simple word-wide register port.
// Notes: Times are kept in milliseconds and counted on a 1 ms tick.
package bcc_pkg;

    localparam int CLK_KHZ = 25_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_KHZ * TICK_MS;

    localparam int MSW = 14;
    localparam logic [MSW-1:0] LONG_MS = 14'h1B58;
    localparam logic [MSW-1:0] SHORT_MS = 14'h07D0;
    localparam logic [MSW-1:0] COMBO_MS = 14'h2710;
    localparam logic [MSW-1:0] HOLD_MAX = 14'h3FFF;
    localparam logic [4:0] DEB_MS = 5'h14;

    localparam logic [3:0] FR_DIAG_A = 4'h9;
    localparam logic [3:0] FR_DIAG_B = 4'h6;
    localparam logic [3:0] INH_MASK = 4'hB;

    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_VARIANT = 8'h04;
    localparam logic [7:0] REG_PIN = 8'h08;
    localparam logic [7:0] REG_MFR = 8'h0C;
    localparam logic [7:0] REG_ADDR_LO = 8'h10;
    localparam logic [7:0] REG_ADDR_HI = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_KEY0 = 8'h20;
    localparam logic [7:0] REG_KEYW0 = 8'h30;

    localparam int CFG_LEARN_INH = 0;
    localparam int CFG_KEY_PRIV = 1;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [31:0] PIN_RST = 32'h0000E215;
    localparam logic [7:0] TEL_LEN = 8'h1D;
    localparam logic [7:0] TEL_TYPE = 8'hFF;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_LONG1 = 2'h1,
        SEQ_SHORT = 2'h3
    } bcc_seq_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } bcc_req_type;

    typedef struct packed {
        logic send_comm;
        logic send_data;
        logic comm_mode;
        logic [3:0] buttons;
    } bcc_tel_type;

endpackage

// ---- tb/bcc_button_model.sv ----
// Purpose: Four bouncing contacts and two telegram request counters.
// Assumes: Tasks are entered right after a rising clock edge.
// Notes: hold times are given in ticks of TICK_CYCLES clocks; level times and the chatter bursts are given in clocks.
`timescale 1ns/1ps
module bcc_button_model
    import bcc_pkg::*;
#(
    parameter int TICK_CYCLES = 2
) (
    input wire logic i_clk,
    input wire bcc_tel_type i_tel,
    output logic [3:0] o_contacts
);
    int comm_cnt = 0;
    int data_cnt = 0;
    initial o_contacts = 4'h0;
    always @(posedge i_clk) begin
        if (i_tel.send_comm === 1'b1)
            comm_cnt <= comm_cnt + 1;
        if (i_tel.send_data === 1'b1)
            data_cnt <= data_cnt + 1;
    end
    task automatic level(input logic [3:0] v, input int cyc);
        o_contacts <= v;
        repeat (cyc) @(posedge i_clk);
    endtask
    // Real contacts chatter; the bursts stay well under the debounce time.
    task automatic hold(input logic [3:0] m, input int ticks);
        level(m, 3);
        level(4'h0, 2);
        level(m, ticks * TICK_CYCLES);
        level(4'h0, 3);
        level(m, 2);
        level(4'h0, 60 * TICK_CYCLES);
    endtask
endmodule

// ---- tb/bcc_ctrl_assertions.sv ----
// Purpose: Port-level checks of commissioning and factory reset.
// Assumes: Single clock domain, reset active low.
// Notes: Bound to every instance of the controller.
`timescale 1ns/1ps
module bcc_ctrl_checker
    import bcc_pkg::*;
#(
    parameter logic [127:0] FACTORY_KEY = 128'h0,
    parameter logic [47:0] FACTORY_ADDR = 48'h0,
    parameter logic [15:0] FACTORY_MFR = 16'h1234
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire bcc_req_type i_req,
    input wire bcc_tel_type o_tel,
    input wire logic [31:0] o_rdata,
    input wire logic [15:0] o_len_type,
    input wire logic [15:0] o_mfr,
    input wire logic [127:0] o_key,
    input wire logic [47:0] o_src_addr,
    input wire logic o_factory_reset,
    input wire logic o_perm_inhibit
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence cfg_wr_rd;
        i_req.wr && i_req.addr == REG_CONFIG ##1 !i_req.wr
            ##1 i_req.rd && i_req.addr == REG_CONFIG;
    endsequence
    sequence restored;
        o_key == FACTORY_KEY && o_mfr == FACTORY_MFR
            && o_src_addr == FACTORY_ADDR && !o_perm_inhibit;
    endsequence
    comm_enter_a: assert property (
        $rose(o_tel.comm_mode) |-> o_tel.send_comm)
        else $error("entry without commissioning telegram");
    comm_only_a: assert property (
        o_tel.send_comm |-> o_tel.comm_mode)
        else $error("commissioning telegram outside the mode");
    exit_data_a: assert property (
        $fell(o_tel.comm_mode) && !o_factory_reset |-> o_tel.send_data)
        else $error("exit without data telegram");
    factory_restore_a: assert property (
        o_factory_reset |-> restored)
        else $error("factory values not restored");
    factory_pulse_a: assert property (
        o_factory_reset |=> !o_factory_reset)
        else $error("factory reset pulse too long");
    len_type_a: assert property (
        $past(i_nrst) |-> o_len_type == 16'h1DFF)
        else $error("length and type bytes wrong");
    cfg_readback_a: assert property (
        cfg_wr_rd |=> o_rdata[1:0] == $past(i_req.wdata[1:0], 3))
        else $error("configuration write not read back");
    perm_hold_a: assert property (
        o_perm_inhibit |=> o_perm_inhibit || o_factory_reset)
        else $error("permanent inhibit lost");
    perm_block_a: assert property (
        o_perm_inhibit |-> !$rose(o_tel.comm_mode))
        else $error("entry while permanently inhibited");
endmodule
bind bcc_ctrl bcc_ctrl_checker #(.FACTORY_KEY(FACTORY_KEY),
    .FACTORY_ADDR(FACTORY_ADDR), .FACTORY_MFR(FACTORY_MFR)) chk (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req), .o_tel(o_tel),
    .o_rdata(o_rdata), .o_len_type(o_len_type), .o_mfr(o_mfr),
    .o_key(o_key), .o_src_addr(o_src_addr),
    .o_factory_reset(o_factory_reset), .o_perm_inhibit(o_perm_inhibit));

// ---- tb/button_commissioning_control_tb.sv ----
// Purpose: Self-checking bench of the commissioning controller.
// Assumes: A one-cycle tick keeps the long holds within the run budget.
// Notes: Each scenario checks its own results.
`timescale 1ns/1ps
module button_commissioning_control_tb;
    import bcc_pkg::*;
    localparam logic [127:0] KEY = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
    localparam logic [47:0] ADR = 48'hC0FFEE123456;
    // Arbitrary neutral maker code.
    localparam logic [15:0] MFR = 16'h5A5A;
    logic i_clk;
    logic i_nrst;
    logic [3:0] contacts;
    bcc_req_type i_req;
    bcc_tel_type tel;
    logic [31:0] rdata;
    logic [15:0] len_type;
    logic [15:0] mfr;
    logic [127:0] key;
    logic [47:0] src;
    logic fr;
    logic perm;
    logic [31:0] rd;
    int mismatches = 0;
    int samples_checked = 0;
    int fr_cnt = 0;
    int c0;
    int d0;
    bcc_ctrl #(.TICK_CYCLES(1), .FACTORY_KEY(KEY), .FACTORY_ADDR(ADR),
        .FACTORY_MFR(MFR)) uut (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_contacts(contacts), .i_req(i_req), .o_rdata(rdata),
        .o_tel(tel), .o_len_type(len_type), .o_mfr(mfr), .o_key(key),
        .o_src_addr(src), .o_factory_reset(fr), .o_perm_inhibit(perm));
    bcc_button_model #(.TICK_CYCLES(1)) m (.i_clk(i_clk), .i_tel(tel),
        .o_contacts(contacts));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (fr === 1'b1) fr_cnt <= fr_cnt + 1;
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        i_req.wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a);
        @(posedge i_clk);
        i_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge i_clk);
        i_req.rd <= 1'b0;
        @(posedge i_clk);
        rd = rdata;
    endtask
    task automatic entry_seq();
        c0 = m.comm_cnt;
        d0 = m.data_cnt;
        m.hold(4'h4, 7050);
        m.hold(4'h4, 500);
        m.hold(4'h4, 7050);
    endtask
    task automatic t_regs();
        reg_rd(REG_CONFIG);
        check(rd, 32'h0);
        check(len_type, 16'h1DFF);
        reg_rd(REG_PIN);
        check(rd, 32'h0);
        reg_rd(8'hFC);
        check(rd, 32'h0);
        m.level(4'h2, 10);
        check(tel.buttons, 4'h0);
        m.level(4'h2, 40);
        check(tel.buttons, 4'h2);
        m.level(4'h0, 40);
        check(tel.buttons, 4'h0);
    endtask
    task automatic t_refused();
        reg_wr(REG_CONFIG, 32'h1);
        reg_rd(REG_CONFIG);
        check(rd, 32'h1);
        entry_seq();
        check(m.comm_cnt - c0, 0);
        check(m.data_cnt - d0, 6);
        check(tel.comm_mode, 1'b0);
    endtask
    task automatic t_entry();
        reg_wr(REG_CONFIG, 32'h0);
        entry_seq();
        check(m.comm_cnt - c0, 1);
        check(tel.comm_mode, 1'b1);
        reg_rd(REG_STATUS);
        check(rd[3:0], 4'h9);
        m.hold(4'h4, 100);
        check(m.comm_cnt - c0, 3);
        d0 = m.data_cnt;
        m.hold(4'h1, 100);
        check(tel.comm_mode, 1'b0);
        check(m.data_cnt - d0, 2);
        check(m.comm_cnt - c0, 3);
    endtask
    task automatic t_inhibit();
        m.hold(4'hB, 10050);
        check(perm, 1'b1);
        check(fr_cnt, 0);
        entry_seq();
        check(m.comm_cnt - c0, 0);
        check(m.data_cnt - d0, 6);
        check(tel.comm_mode, 1'b0);
    endtask
    task automatic t_factory();
        reg_wr(REG_CONFIG, 32'h2);
        reg_wr(REG_VARIANT, 32'h5);
        reg_wr(REG_MFR, 32'hBEEF);
        reg_wr(REG_ADDR_LO, 32'h11111111);
        reg_wr(REG_PIN, 32'h13572468);
        reg_wr(REG_KEYW0, 32'hA5A5A5A5);
        check(uut.s.pin, 32'h13572468);
        reg_rd(REG_KEY0);
        check(rd, 32'h0);
        m.hold(4'h6, 10050);
        check(fr_cnt, 1);
        check(perm, 1'b0);
        check(key, KEY);
        check(src, ADR);
        check(mfr, MFR);
        reg_rd(REG_CONFIG);
        check(rd, 32'h0);
        reg_rd(REG_VARIANT);
        check(rd, 32'h0);
        reg_rd(REG_KEY0);
        check(rd, KEY[31:0]);
        check(uut.s.pin, 32'h0000E215);
        entry_seq();
        check(m.comm_cnt - c0, 1);
        check(tel.comm_mode, 1'b1);
    endtask
    task automatic finish_test();
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (95000) @(posedge i_clk);
        mismatches++;
        finish_test();
    end
    initial begin
        i_nrst = 1'b0;
        i_req = '0;
        repeat (10) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        t_regs();
        t_refused();
        t_entry();
        t_inhibit();
        t_factory();
        finish_test();
    end
endmodule
